// file: common/pelr_pkg.sv
// Package with the register map, field layout and carrier types of the protocol log block.
package pelr_pkg;
    // Shared-memory word addresses of the log areas and log-option words.
    localparam logic [15:0] LOG_BASE_ONE = 16'h4102;
    localparam logic [15:0] LOG_BASE_TWO = 16'h4802;
    localparam logic [15:0] LOG_AREA_WORDS = 16'h0600;
    localparam logic [15:0] LOG_STRIDE = 16'h0030;
    localparam logic [15:0] OPT_ADDR_ONE = 16'h40e2;
    localparam logic [15:0] OPT_ADDR_TWO = 16'h40f2;
    // Block-local control and status words.
    localparam logic [15:0] PSET_ADDR_ONE = 16'h4f00;
    localparam logic [15:0] PSET_ADDR_TWO = 16'h4f01;
    localparam logic [15:0] READY_ADDR = 16'h4f02;
    localparam logic [15:0] XSTAT_ADDR = 16'h4f03;
    localparam logic [15:0] ERR_ADDR = 16'h4f04;
    localparam logic [15:0] CANCEL_ADDR = 16'h4f05;
    localparam logic [15:0] COUNT_ADDR_ONE = 16'h4f06;
    localparam logic [15:0] COUNT_ADDR_TWO = 16'h4f07;
    localparam logic [15:0] IRQ_STAT_ADDR = 16'h4f08;
    localparam logic [15:0] IRQ_MASK_ADDR = 16'h4f09;
    // Field positions and values.
    localparam int OPT_ALL_BIT = 0;
    localparam logic [3:0] PSET_PREDEF = 4'h9;
    localparam int LOG_DEPTH = 32;
    localparam logic [5:0] LOG_FULL = 6'h20;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // Interrupt status bits.
    localparam int IRQ_DONE_ONE = 0;
    localparam int IRQ_DONE_TWO = 1;
    localparam int IRQ_FAIL = 2;
    localparam int IRQ_REJECT = 3;
    localparam int IRQ_BITS = 4;
    // Per-channel execution status codes.
    typedef enum logic [1:0] {PELR_IDLE, PELR_RUN, PELR_OK, PELR_FAIL} pelr_xstat_t;
    // Execute command from the sequencer side.
    typedef struct packed {
        logic valid;
        logic ch;
        logic functional;
        logic [7:0] proto;
    } pelr_cmd_t;
    // Completion report from the protocol engine.
    typedef struct packed {
        logic valid;
        logic ch;
        logic fail;
        logic cancel;
        logic [15:0] err;
    } pelr_done_t;
endpackage : pelr_pkg

// file: core/pelr_core.sv
// Protocol execution log store, status words and ready gating for two serial channels.
//
// Behaviour
// - Keep up to 32 execution log entries per channel, all readable.
// - A new entry after 32 held overwrites the oldest one.
// - Channel one logs start at word 4102h, channel two at 4802h.
// - Error-only option records only executions that failed.
// - All-logs option records every execution, success or failure.
// - Writable log-option word per channel at 40E2h and 40F2h.
// - Option change applies only when the next execute command is accepted.
// - Non-functional protocol executions run only while the ready flag is high.
// - With ready low, functional protocol commands still run; others are refused.
// - Ready is high only while some channel selects predefined protocol mode.
// - Keep a readable count of protocol executions.
// - Expose the most recent protocol fault code.
// - Expose cancel status and current execution status.
// - No modem communication on a channel in predefined protocol mode.
// - Ready drops during stored-data verification, returns only on success.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module pelr_core (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire pelr_pkg::pelr_cmd_t i_cmd,
    input wire pelr_pkg::pelr_done_t i_done,
    input wire logic i_verify_start,
    input wire logic i_verify_end,
    input wire logic i_verify_ok,
    output logic o_exec_start,
    output logic o_exec_reject,
    output logic o_ready,
    output logic [1:0] o_modem_en,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [15:0] opt_ff [2];
    logic [3:0] pset_ff [2];
    logic [1:0] opt_act_ff;
    logic [4:0] wptr_ff [2];
    logic [5:0] held_ff [2];
    logic [15:0] count_ff [2];
    logic [15:0] log_w0_ff [2][pelr_pkg::LOG_DEPTH];
    logic [15:0] log_w1_ff [2][pelr_pkg::LOG_DEPTH];
    pelr_pkg::pelr_xstat_t xstat_ff [2];
    logic [1:0] cancel_ff;
    logic [15:0] err_ff;
    logic [7:0] proto_ff [2];
    logic verifying_ff;
    logic verify_ok_ff;
    logic ready_ff;
    logic [pelr_pkg::IRQ_BITS-1:0] irq_stat_ff;
    logic [pelr_pkg::IRQ_BITS-1:0] irq_mask_ff;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic [1:0] predef;
    logic accept;
    logic reject;
    logic [1:0] log_we;

    ////////////////////////////////////////////////////////////////////////////
    // Command gating. A functional command passes even while ready is low.
    assign accept = i_cmd.valid && (ready_ff || i_cmd.functional);
    assign reject = i_cmd.valid && !accept;
    assign o_exec_start = accept;
    assign o_exec_reject = reject;
    assign o_ready = ready_ff;
    assign o_rdata = rdata_ff;
    assign o_irq = |(irq_stat_ff & irq_mask_ff);

    ////////////////////////////////////////////////////////////////////////////
    // Verification of stored protocol settings holds ready low until it passes.
    // The ok flag starts high because unwritten settings count as normal.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            verifying_ff <= 1'b0;
            verify_ok_ff <= 1'b1;
        end else if (i_verify_start) begin
            verifying_ff <= 1'b1;
            verify_ok_ff <= 1'b0;
        end else if (i_verify_end && verifying_ff) begin
            verifying_ff <= 1'b0;
            verify_ok_ff <= i_verify_ok;
        end
    end

    // Ready follows the mode settings and the verification result.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= (|predef) && verify_ok_ff && !verifying_ff && !i_verify_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel settings, log store and counters.
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            logic [15:0] opt_addr;
            logic [15:0] pset_addr;
            logic is_cmd;
            logic is_done;
            assign opt_addr = (ch == 0) ? pelr_pkg::OPT_ADDR_ONE : pelr_pkg::OPT_ADDR_TWO;
            assign pset_addr = (ch == 0) ? pelr_pkg::PSET_ADDR_ONE : pelr_pkg::PSET_ADDR_TWO;
            assign is_cmd = accept && (i_cmd.ch == 1'(ch));
            assign is_done = i_done.valid && (i_done.ch == 1'(ch));
            assign predef[ch] = (pset_ff[ch] == pelr_pkg::PSET_PREDEF);
            assign o_modem_en[ch] = !predef[ch];
            // Error-only mode logs failures; all-logs mode logs everything.
            assign log_we[ch] = is_done && (opt_act_ff[ch] || i_done.fail);

            // Software words: option and protocol setting.
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    opt_ff[ch] <= pelr_pkg::RESET_WORD;
                    pset_ff[ch] <= 4'h0;
                end else if (i_wr && i_addr == opt_addr) begin
                    opt_ff[ch] <= i_wdata;
                end else if (i_wr && i_addr == pset_addr) begin
                    pset_ff[ch] <= i_wdata[3:0];
                end
            end

            // The working option is copied only at command acceptance, so a
            // write mid-execution cannot split one execution's logging policy.
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    opt_act_ff[ch] <= 1'b0;
                    proto_ff[ch] <= 8'h00;
                end else if (is_cmd) begin
                    opt_act_ff[ch] <= opt_ff[ch][pelr_pkg::OPT_ALL_BIT];
                    proto_ff[ch] <= i_cmd.proto;
                end
            end

            // Circular pointer; wraps over the oldest entry once 32 are held.
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    wptr_ff[ch] <= 5'h00;
                    held_ff[ch] <= 6'h00;
                end else if (log_we[ch]) begin
                    wptr_ff[ch] <= wptr_ff[ch] + 5'h01;
                    if (held_ff[ch] != pelr_pkg::LOG_FULL) begin
                        held_ff[ch] <= held_ff[ch] + 6'h01;
                    end
                end
            end

            // Entry words: flags with protocol number, then the fault code.
            always_ff @(posedge i_core_clk) begin
                if (log_we[ch]) begin
                    log_w0_ff[ch][wptr_ff[ch]] <= {i_done.fail, i_done.cancel, 6'h00, proto_ff[ch]};
                    log_w1_ff[ch][wptr_ff[ch]] <= i_done.err;
                end
            end

            // Execution count, status and cancel flag.
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    count_ff[ch] <= 16'h0000;
                    xstat_ff[ch] <= pelr_pkg::PELR_IDLE;
                    cancel_ff[ch] <= 1'b0;
                end else if (is_done) begin
                    count_ff[ch] <= count_ff[ch] + 16'h0001;
                    xstat_ff[ch] <= i_done.fail ? pelr_pkg::PELR_FAIL : pelr_pkg::PELR_OK;
                    cancel_ff[ch] <= i_done.cancel;
                end else if (is_cmd) begin
                    xstat_ff[ch] <= pelr_pkg::PELR_RUN;
                    cancel_ff[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // Most recent fault code of either channel.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            err_ff <= 16'h0000;
        end else if (i_done.valid && i_done.fail) begin
            err_ff <= i_done.err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status: write one to clear, a same-cycle event wins the clear.
    logic [pelr_pkg::IRQ_BITS-1:0] irq_set;
    logic [pelr_pkg::IRQ_BITS-1:0] irq_clr;
    assign irq_set[pelr_pkg::IRQ_DONE_ONE] = i_done.valid && !i_done.ch;
    assign irq_set[pelr_pkg::IRQ_DONE_TWO] = i_done.valid && i_done.ch;
    assign irq_set[pelr_pkg::IRQ_FAIL] = i_done.valid && i_done.fail;
    assign irq_set[pelr_pkg::IRQ_REJECT] = reject;
    assign irq_clr = (i_wr && i_addr == pelr_pkg::IRQ_STAT_ADDR) ? i_wdata[pelr_pkg::IRQ_BITS-1:0] : 4'h0;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_stat_ff <= 4'h0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    // Interrupt mask.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_mask_ff <= 4'h0;
        end else if (i_wr && i_addr == pelr_pkg::IRQ_MASK_ADDR) begin
            irq_mask_ff <= i_wdata[pelr_pkg::IRQ_BITS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read decode. Log words past the two stored per entry read as zero,
    // which keeps the store small while the full area stays addressable.
    logic [15:0] off1;
    logic [15:0] off2;
    logic [15:0] loff;
    logic lch;
    logic [4:0] lidx;
    logic [15:0] lwd;
    assign off1 = i_addr - pelr_pkg::LOG_BASE_ONE;
    assign off2 = i_addr - pelr_pkg::LOG_BASE_TWO;
    assign lch = (i_addr >= pelr_pkg::LOG_BASE_TWO);
    assign loff = lch ? off2 : off1;
    assign lidx = 5'(loff / pelr_pkg::LOG_STRIDE);
    assign lwd = loff % pelr_pkg::LOG_STRIDE;

    always_comb begin
        nxt_rdata = 16'h0000;
        if (i_addr >= pelr_pkg::LOG_BASE_ONE && off1 < pelr_pkg::LOG_AREA_WORDS
            || i_addr >= pelr_pkg::LOG_BASE_TWO && off2 < pelr_pkg::LOG_AREA_WORDS) begin
            if (lwd == 16'h0000) begin
                nxt_rdata = log_w0_ff[lch][lidx];
            end else if (lwd == 16'h0001) begin
                nxt_rdata = log_w1_ff[lch][lidx];
            end
        end else if (i_addr == pelr_pkg::OPT_ADDR_ONE) begin
            nxt_rdata = opt_ff[0];
        end else if (i_addr == pelr_pkg::OPT_ADDR_TWO) begin
            nxt_rdata = opt_ff[1];
        end else if (i_addr == pelr_pkg::PSET_ADDR_ONE) begin
            nxt_rdata = {12'h000, pset_ff[0]};
        end else if (i_addr == pelr_pkg::PSET_ADDR_TWO) begin
            nxt_rdata = {12'h000, pset_ff[1]};
        end else if (i_addr == pelr_pkg::READY_ADDR) begin
            nxt_rdata = {13'h0000, verify_ok_ff, verifying_ff, ready_ff};
        end else if (i_addr == pelr_pkg::XSTAT_ADDR) begin
            nxt_rdata = {4'h0, held_ff[1][5:4], xstat_ff[1], 6'h00, xstat_ff[0]};
        end else if (i_addr == pelr_pkg::ERR_ADDR) begin
            nxt_rdata = err_ff;
        end else if (i_addr == pelr_pkg::CANCEL_ADDR) begin
            nxt_rdata = {14'h0000, cancel_ff};
        end else if (i_addr == pelr_pkg::COUNT_ADDR_ONE) begin
            nxt_rdata = count_ff[0];
        end else if (i_addr == pelr_pkg::COUNT_ADDR_TWO) begin
            nxt_rdata = count_ff[1];
        end else if (i_addr == pelr_pkg::IRQ_STAT_ADDR) begin
            nxt_rdata = {12'h000, irq_stat_ff};
        end else if (i_addr == pelr_pkg::IRQ_MASK_ADDR) begin
            nxt_rdata = {12'h000, irq_mask_ff};
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= i_rd ? nxt_rdata : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_verify_begin;
        i_verify_start;
    endsequence

    sequence s_ready_low_run;
        !o_ready [*2];
    endsequence

    a_ready_needs_mode: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_ready |-> $past(|predef))
        else $error("Ready high with no channel in predefined mode.");

    a_verify_drops_ready: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_verify_begin |=> s_ready_low_run)
        else $error("Ready not low during verification.");

    a_nonfunc_refused: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_cmd.valid && !o_ready && !i_cmd.functional |-> o_exec_reject && !o_exec_start)
        else $error("Non-functional command accepted while not ready.");

    a_functional_passes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_cmd.valid && i_cmd.functional |-> o_exec_start ##1 xstat_ff[$past(i_cmd.ch)] == pelr_pkg::PELR_RUN
        || $past(i_done.valid && i_done.ch == i_cmd.ch))
        else $error("Functional command not started.");

    a_option_latch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !(accept && !i_cmd.ch) |=> opt_act_ff[0] == $past(opt_act_ff[0]))
        else $error("Working option changed without a command.");

    a_error_only_skip: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_done.valid && !i_done.ch && !i_done.fail && !opt_act_ff[0] |=> wptr_ff[0] == $past(wptr_ff[0]))
        else $error("Successful execution logged in error-only mode.");

    a_all_logs_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_done.valid && !i_done.ch && opt_act_ff[0] |=> wptr_ff[0] == 5'($past(wptr_ff[0]) + 5'h01))
        else $error("Execution not logged in all-logs mode.");

    a_count_step: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_done.valid && i_done.ch |=> count_ff[1] == 16'($past(count_ff[1]) + 16'h0001))
        else $error("Execution count did not advance.");

    a_err_readback: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_rd && i_addr == pelr_pkg::ERR_ADDR |=> o_rdata == $past(err_ff))
        else $error("Error code read back wrong.");

    a_modem_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        pset_ff[1] == pelr_pkg::PSET_PREDEF |-> !o_modem_en[1])
        else $error("Modem enabled in predefined mode.");

endmodule : pelr_core

// file: dv/pelr_engine_model.sv
// Behavioural protocol engine that answers each accepted execute command given a nonzero delay with one completion report.
`timescale 1ns/10ps
module pelr_engine_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_exec_start,
    input wire pelr_pkg::pelr_cmd_t i_cmd,
    input wire logic [3:0] i_delay,
    output pelr_pkg::pelr_done_t o_done
);
    logic [3:0] cnt_ff;
    pelr_pkg::pelr_cmd_t job_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // One job at a time; the delay input lets the bench ask for a prompt or a slow answer.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cnt_ff <= 4'h0;
            job_ff <= '0;
        end else if (i_exec_start) begin
            cnt_ff <= i_delay;
            job_ff <= i_cmd;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Odd protocol numbers fail and bit one asks for a cancel, so the bench commands every outcome.
    always_comb begin
        o_done = '0;
        o_done.valid = (cnt_ff == 4'h1);
        o_done.ch = job_ff.ch;
        o_done.fail = job_ff.proto[0];
        o_done.cancel = job_ff.proto[1];
        o_done.err = {8'he0, job_ff.proto};
    end
endmodule : pelr_engine_model

// file: dv/tb_protocol_exec_log_and_ready.sv
// Self-checking bench of the protocol log block, driven through its register port and command port.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_protocol_exec_log_and_ready;
    logic i_core_clk = 1'b0;
    logic i_rst_n, i_wr, i_rd, vstart, vend, vok, o_exec_start, o_exec_reject, o_ready, o_irq;
    logic [15:0] i_addr, i_wdata, o_rdata;
    logic [1:0] o_modem_en;
    logic [3:0] delay;
    pelr_pkg::pelr_cmd_t cmd;
    pelr_pkg::pelr_done_t done;
    int miscompares = 0;
    int n_tests = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // The clock inverts every half period of 20 ns.
    always #20 i_core_clk = ~i_core_clk;
    pelr_core i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmd(cmd), .i_done(done), .i_verify_start(vstart),
        .i_verify_end(vend), .i_verify_ok(vok), .o_exec_start(o_exec_start), .o_exec_reject(o_exec_reject),
        .o_ready(o_ready), .o_modem_en(o_modem_en), .o_irq(o_irq));
    pelr_engine_model i_engine (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_exec_start(o_exec_start),
        .i_cmd(cmd), .i_delay(delay), .o_done(done));
    ////////////////////////////////////////////////////////////////////////////////
    // Register writes and reads; read data stand only in the cycle after the strobe.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        `CHK($sformatf("word %h", a), e, o_rdata)
    endtask : rd
    // Commands are held for one cycle; acceptance is combinational in that cycle.
    task automatic issue(input logic ch, input logic fn, input logic [7:0] pr, input logic ok,
        input logic [3:0] dl);
        @(posedge i_core_clk);
        delay <= dl;
        cmd <= '{valid: 1'b1, ch: ch, functional: fn, proto: pr};
        #1;
        `CHK("exec start", ok, o_exec_start)
        `CHK("exec reject", !ok, o_exec_reject)
        @(posedge i_core_clk);
        cmd <= '0;
    endtask : issue
    // The wait is bounded so a lost completion shows up as a mismatch, not a hang.
    task automatic await_done();
        int k;
        k = 0;
        do begin
            @(negedge i_core_clk);
            k++;
        end while (done.valid !== 1'b1 && k < 40);
        `CHK("completion seen", 1'b1, done.valid)
        @(posedge i_core_clk);
        #1;
    endtask : await_done
    task automatic run(input logic ch, input logic [7:0] pr, input logic [3:0] dl);
        issue(ch, 1'b0, pr, 1'b1, dl);
        await_done();
    endtask : run
    // Verification of stored settings, passing or failing as asked.
    task automatic verify(input logic ok);
        @(posedge i_core_clk);
        vstart <= 1'b1;
        @(posedge i_core_clk);
        vstart <= 1'b0;
        @(posedge i_core_clk);
        #1;
        `CHK("ready while verifying", 1'b0, o_ready)
        @(posedge i_core_clk);
        vok <= ok;
        vend <= 1'b1;
        @(posedge i_core_clk);
        vend <= 1'b0;
        @(posedge i_core_clk);
        #1;
        `CHK("ready after verify", ok, o_ready)
    endtask : verify
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    // The watchdog allows many times the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge i_core_clk);
        miscompares++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 16'h0000;
        i_wdata = 16'h0000;
        vstart = 1'b0;
        vend = 1'b0;
        vok = 1'b1;
        delay = 4'h3;
        cmd = '0;
        repeat (20) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        #1;
        `CHK("ready at reset", 1'b0, o_ready)
        `CHK("modem at reset", 2'b11, o_modem_en)
        rd(pelr_pkg::OPT_ADDR_ONE, 16'h0000);
        rd(pelr_pkg::READY_ADDR, 16'h0004);
        rd(16'h0000, 16'h0000);
        $display("test reset done");
        issue(1'b0, 1'b0, 8'h10, 1'b0, 4'h3);
        issue(1'b0, 1'b1, 8'h20, 1'b1, 4'h1);
        await_done();
        rd(pelr_pkg::IRQ_STAT_ADDR, 16'h0009);
        `CHK("irq masked", 1'b0, o_irq)
        wr(pelr_pkg::IRQ_MASK_ADDR, 16'h0008);
        `CHK("irq unmasked", 1'b1, o_irq)
        wr(pelr_pkg::IRQ_STAT_ADDR, 16'h0008);
        `CHK("irq cleared", 1'b0, o_irq)
        rd(pelr_pkg::IRQ_STAT_ADDR, 16'h0001);
        $display("test gating and interrupt done");
        wr(pelr_pkg::PSET_ADDR_TWO, {12'h000, pelr_pkg::PSET_PREDEF});
        repeat (2) @(posedge i_core_clk);
        #1;
        `CHK("ready mode two", 1'b1, o_ready)
        `CHK("modem mode two", 2'b01, o_modem_en)
        wr(pelr_pkg::PSET_ADDR_TWO, 16'h0000);
        repeat (2) @(posedge i_core_clk);
        #1;
        `CHK("ready no mode", 1'b0, o_ready)
        wr(pelr_pkg::PSET_ADDR_ONE, {12'h000, pelr_pkg::PSET_PREDEF});
        repeat (2) @(posedge i_core_clk);
        #1;
        `CHK("modem mode one", 2'b10, o_modem_en)
        verify(1'b0);
        rd(pelr_pkg::READY_ADDR, 16'h0000);
        verify(1'b1);
        rd(pelr_pkg::READY_ADDR, 16'h0005);
        $display("test ready done");
        // Host side keeps the interlock from here on: commands only while ready.
        `CHK("ready before commands", 1'b1, o_ready)
        issue(1'b0, 1'b0, 8'h22, 1'b1, 4'hc);
        wr(pelr_pkg::OPT_ADDR_ONE, 16'h0001);
        await_done();
        rd(pelr_pkg::OPT_ADDR_ONE, 16'h0001);
        run(1'b0, 8'h31, 4'h2);
        run(1'b0, 8'h40, 4'h1);
        // No log fetch by the setup tool runs in this bench, so the host may read the log area freely.
        rd(pelr_pkg::LOG_BASE_ONE, 16'h8031);
        rd(pelr_pkg::LOG_BASE_ONE + 16'h0001, 16'he031);
        rd(pelr_pkg::LOG_BASE_ONE + pelr_pkg::LOG_STRIDE, 16'h0040);
        for (int i = 2; i < 32; i++) begin
            run(1'b0, 8'(i * 4), 4'h2);
        end
        rd(pelr_pkg::LOG_BASE_ONE + 16'(16'(31) * pelr_pkg::LOG_STRIDE), 16'h007c);
        run(1'b0, 8'h84, 4'h2);
        rd(pelr_pkg::LOG_BASE_ONE, 16'h0084);
        rd(pelr_pkg::LOG_BASE_ONE + pelr_pkg::LOG_STRIDE, 16'h0040);
        rd(pelr_pkg::COUNT_ADDR_ONE, 16'h0023);
        rd(pelr_pkg::XSTAT_ADDR, 16'h0002);
        rd(pelr_pkg::ERR_ADDR, 16'he031);
        rd(pelr_pkg::CANCEL_ADDR, 16'h0000);
        $display("test channel one log done");
        wr(pelr_pkg::OPT_ADDR_TWO, 16'h0001);
        run(1'b1, 8'h13, 4'h4);
        rd(pelr_pkg::LOG_BASE_TWO, 16'hc013);
        rd(pelr_pkg::ERR_ADDR, 16'he013);
        rd(pelr_pkg::CANCEL_ADDR, 16'h0002);
        rd(pelr_pkg::XSTAT_ADDR, 16'h0302);
        rd(pelr_pkg::COUNT_ADDR_TWO, 16'h0001);
        rd(pelr_pkg::IRQ_STAT_ADDR, 16'h0007);
        wr(pelr_pkg::IRQ_STAT_ADDR, 16'h000f);
        rd(pelr_pkg::IRQ_STAT_ADDR, 16'h0000);
        $display("test channel two log done");
        finish_test();
    end
endmodule : tb_protocol_exec_log_and_ready
